//--- src/crf_core_regs.sv
`timescale 1ns/1ps

// What this block does
// RULE1 - 8-bit operand register takes arithmetic results
// RULE2 - Multiply/divide use operand and extension concatenated; divide here gives quotient to operand, remainder to extension
// RULE3 - Four banks, one active by bank bits
// RULE4 - Banks occupy lowest 32 internal RAM bytes
// RULE5 - Reset selects bank 0, stack at 08h
// RULE6 - Bank bits map to 00h/08h/10h/18h bases
// RULE7 - Carry on carry/borrow, shifts update it
// RULE8 - Half carry on nibble carry or borrow
// RULE9 - User flag changed only by software
// RULE10 - Signed error on overflow, product, zero divide
// RULE11 - Arithmetic clears signed error; clear instruction too
// RULE12 - Parity tracks operand register odd bit count
// RULE13 - Special registers only by direct 80h-FFh
// RULE14 - Sixteen special addresses also bit addressable
// RULE15 - Software avoids writing unoccupied special addresses
// RULE16 - Unoccupied special reads return unspecified value
// RULE17 - Stack pointer resets 07h, pre-increment, post-decrement
// RULE18 - Updates visible by next instruction cycle
module crf_core_regs
  import crf_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire crf_alu_req_t   alu_req,
  input  wire crf_mem_req_t   mem_req,
  input  wire crf_work_req_t  work_req,
  input  wire crf_stack_req_t stack_req,
  output logic [7:0]          mem_rdata,
  output logic [7:0]          work_rdata,
  output logic [7:0]          stack_rdata,
  output logic [7:0]          operand_out,
  output logic [7:0]          extension_out,
  output logic [7:0]          status_out,
  output logic [7:0]          stack_top_out,
  output logic [15:0]         data_ptr_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opr;      // Main operand register
    logic [7:0] ext;      // Extension register
    logic       cf;       // Carry flag
    logic       hc;       // Half carry flag
    logic       uf;       // User flag
    logic [1:0] bank;     // Bank select high/low
    logic       serr;     // Signed error flag
    logic       st_bit1;  // Spare status bit, software owned
    logic [7:0] tp;       // Stack top pointer
    logic [7:0] dlo;      // Data pointer low
    logic [7:0] dhi;      // Data pointer high
    logic [7:0] psel;     // Pointer select control
    logic [7:0] pstep;    // Pointer step mode
    logic [7:0] pwr;      // Power and serial control
    logic [7:0] tmr;      // Timer 0/1 control
    logic [7:0] mem_rd;   // Registered read data
    logic [7:0] work_rd;  // Registered working read
    logic [7:0] stk_rd;   // Registered pop data
  } crf_state_t;

  crf_state_t st_reg;    // Current state
  crf_state_t st_next;   // Next state

  // Internal data RAM; low 32 bytes double as the register banks
  logic [7:0] iram [IRAM_DEPTH];

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic [7:0]  bank_base;    // Start address of the active bank
  logic [7:0]  work_addr;    // RAM address of the working register
  logic        parity;       // Odd parity of operand register
  logic [7:0]  status_word;  // Assembled status byte
  logic        is_spr;       // Direct access above 7Fh
  logic        bit_capable;  // Address ends in 0 or 8
  logic [8:0]  sum9;         // Full add/sub result
  logic [4:0]  sum5;         // Low nibble add/sub result
  logic        cin;          // Carry in for add with carry
  logic [15:0] product;      // Multiply result
  logic [7:0]  quotient;     // Divide quotient
  logic [7:0]  remainder;    // Divide remainder
  logic [7:0]  tp_inc;       // Pre-incremented stack pointer
  logic [7:0]  spr_rd;       // Special register read mux
  logic [7:0]  ram_wr_addr;  // RAM write address
  logic [7:0]  ram_wr_data;  // RAM write data
  logic        ram_wr_en;    // RAM write enable

  // Bank base is bank number times eight
  assign bank_base = {3'b000, st_reg.bank, 3'b000};                     // RULE6
  // Working registers live in RAM, so they share storage with data
  assign work_addr = bank_base | {5'b00000, work_req.index};            // RULE3 RULE4
  assign parity    = ^st_reg.opr;                                       // RULE12
  assign status_word = {st_reg.cf, st_reg.hc, st_reg.uf, st_reg.bank,
                        st_reg.serr, st_reg.st_bit1, parity};
  // Indirect accesses above 7Fh fall through to RAM
  assign is_spr    = mem_req.direct && (mem_req.addr >= SPR_BASE);      // RULE13
  // Bit addressable: 80h,88h,...,F8h gives sixteen addresses
  assign bit_capable = (mem_req.addr >= BIT_SPR_MIN) &&
                       (mem_req.addr[2:0] == 3'b000);                   // RULE14
  assign cin       = (alu_req.op == CRF_OP_ADDC) ? st_reg.cf : 1'b0;
  assign tp_inc    = st_reg.tp + 8'h01;
  assign product   = st_reg.opr * st_reg.ext;                           // RULE2
  // Zero divide gives a don't-care result; hold zeros to stay defined
  assign quotient  = (st_reg.ext == RST_ZERO) ? RST_ZERO : st_reg.opr / st_reg.ext;
  assign remainder = (st_reg.ext == RST_ZERO) ? RST_ZERO : st_reg.opr % st_reg.ext;

  // Add or subtract-with-borrow on full byte and low nibble
  always_comb begin
    if (alu_req.op == CRF_OP_SUBB) begin
      sum9 = {1'b0, st_reg.opr} - {1'b0, alu_req.operand} - {8'h00, st_reg.cf};
      sum5 = {1'b0, st_reg.opr[3:0]} - {1'b0, alu_req.operand[3:0]} - {4'h0, st_reg.cf};
    end else begin
      sum9 = {1'b0, st_reg.opr} + {1'b0, alu_req.operand} + {8'h00, cin};
      sum5 = {1'b0, st_reg.opr[3:0]} + {1'b0, alu_req.operand[3:0]} + {4'h0, cin};
    end
  end

  // Special register read mux
  always_comb begin
    unique case (mem_req.addr)
      ADDR_STACK_TOP: spr_rd = st_reg.tp;
      ADDR_DPTR_LOW:  spr_rd = st_reg.dlo;
      ADDR_DPTR_HIGH: spr_rd = st_reg.dhi;
      ADDR_PTR_SEL:   spr_rd = st_reg.psel;
      ADDR_PTR_STEP:  spr_rd = st_reg.pstep;
      ADDR_PWR_SER:   spr_rd = st_reg.pwr;
      ADDR_TMR01_CTL: spr_rd = st_reg.tmr;
      ADDR_STATUS:    spr_rd = status_word;
      ADDR_OPERAND:   spr_rd = st_reg.opr;
      ADDR_EXTEND:    spr_rd = st_reg.ext;
      // Unoccupied addresses: content is unspecified, zero is chosen
      default:        spr_rd = UNMAPPED_READ;                           // RULE16
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Order: special register write, then working register and stack, then arithmetic.
  // Arithmetic wins over a same-cycle software write of a flag,
  // since the write and the instruction cannot really coincide.
  always_comb begin
    logic [7:0] wval;      // Byte after bit merge
    logic [7:0] cur;       // Current value for bit merge
    st_next = st_reg;
    wval = mem_req.wdata;
    cur  = spr_rd;
    ram_wr_en   = 1'b0;
    ram_wr_addr = RST_ZERO;
    ram_wr_data = RST_ZERO;

    // Bit write merges one bit into the current byte
    if (mem_req.bit_mode && bit_capable) begin                          // RULE14
      wval = cur;
      wval[mem_req.bit_sel] = mem_req.wbit;
    end

    // Byte or bit writes to memory space
    if (mem_req.valid && mem_req.write) begin
      if (is_spr) begin                                                 // RULE13
        unique case (mem_req.addr)
          ADDR_STACK_TOP: st_next.tp    = wval;
          ADDR_DPTR_LOW:  st_next.dlo   = wval;
          ADDR_DPTR_HIGH: st_next.dhi   = wval;
          ADDR_PTR_SEL:   st_next.psel  = wval;
          ADDR_PTR_STEP:  st_next.pstep = wval;
          ADDR_PWR_SER:   st_next.pwr   = wval;
          ADDR_TMR01_CTL: st_next.tmr   = wval;
          ADDR_STATUS: begin
            // Parity is derived, its written value is dropped
            st_next.cf      = wval[ST_CARRY];
            st_next.hc      = wval[ST_HALF];
            st_next.uf      = wval[ST_USER];                            // RULE9
            st_next.bank    = {wval[ST_BSH], wval[ST_BSL]};             // RULE3
            st_next.serr    = wval[ST_SERR];
            st_next.st_bit1 = wval[1];
          end
          ADDR_OPERAND:   st_next.opr = wval;                           // RULE1
          ADDR_EXTEND:    st_next.ext = wval;
          // Writes to unoccupied addresses are dropped
          default:        st_next.st_bit1 = st_reg.st_bit1;             // RULE15
        endcase
      end else begin
        ram_wr_en   = 1'b1;
        ram_wr_addr = mem_req.addr;
        ram_wr_data = mem_req.wdata;
      end
    end

    // Working register write lands in the active bank
    if (work_req.valid && work_req.write) begin                         // RULE3
      ram_wr_en   = 1'b1;
      ram_wr_addr = work_addr;
      ram_wr_data = work_req.wdata;
    end

    // Push pre-increments; pop reads then post-decrements
    if (stack_req.push) begin                                           // RULE17
      st_next.tp  = tp_inc;
      ram_wr_en   = 1'b1;
      ram_wr_addr = tp_inc;
      ram_wr_data = stack_req.wdata;
    end else if (stack_req.pop) begin
      st_next.tp = st_reg.tp - 8'h01;                                   // RULE17
    end

    // Arithmetic and flag updates, visible next cycle
    unique case (alu_req.op)                                            // RULE18
      CRF_OP_ADD, CRF_OP_ADDC, CRF_OP_SUBB: begin
        st_next.opr = sum9[7:0];                                        // RULE1
        st_next.cf  = sum9[8];                                          // RULE7
        st_next.hc  = sum5[4];                                          // RULE8
        if (alu_req.op == CRF_OP_SUBB) begin
          st_next.serr = (st_reg.opr[7] != alu_req.operand[7]) &&
                         (sum9[7] != st_reg.opr[7]);                    // RULE10 RULE11
        end else begin
          st_next.serr = (st_reg.opr[7] == alu_req.operand[7]) &&
                         (sum9[7] != st_reg.opr[7]);                    // RULE10 RULE11
        end
      end
      CRF_OP_MUL: begin
        {st_next.ext, st_next.opr} = product;                           // RULE2
        st_next.cf   = 1'b0;                                            // RULE7
        st_next.hc   = 1'b0;                                            // RULE8
        st_next.serr = (product[15:8] != RST_ZERO);                     // RULE10 RULE11
      end
      CRF_OP_DIV: begin
        st_next.opr  = quotient;                                        // RULE2
        st_next.ext  = remainder;
        st_next.cf   = 1'b0;                                            // RULE7
        st_next.hc   = 1'b0;                                            // RULE8
        st_next.serr = (st_reg.ext == RST_ZERO);                        // RULE10 RULE11
      end
      CRF_OP_SHIFT: begin
        // Execution unit computes the shifted byte and carry out
        st_next.opr = alu_req.operand;
        st_next.cf  = alu_req.shift_carry;                              // RULE7
      end
      CRF_OP_VCLR: begin
        st_next.serr = 1'b0;                                            // RULE11
      end
      CRF_OP_OTHER_ARITH: begin
        st_next.opr = alu_req.operand;
        st_next.cf  = 1'b0;                                             // RULE7
        st_next.hc  = 1'b0;                                             // RULE8
      end
      CRF_OP_NONE: begin
        st_next.opr = st_next.opr;
      end
      // Illegal op code: hold everything
      default: begin
        st_next.opr = st_next.opr;
      end
    endcase

    // Registered read paths
    if (mem_req.valid && !mem_req.write) begin
      st_next.mem_rd = is_spr ? spr_rd : iram[mem_req.addr];            // RULE13
    end
    if (work_req.valid && !work_req.write) begin
      st_next.work_rd = iram[work_addr];                                // RULE3
    end
    if (stack_req.pop) begin
      st_next.stk_rd = iram[st_reg.tp];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset: bank 0 active, stack pointer 07h so first push hits 08h
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg      <= '0;                                                // RULE5
      st_reg.tp   <= RST_STACK_TOP;                                     // RULE5 RULE17
    end else begin
      st_reg <= st_next;
    end
  end

  // RAM holds no reset; contents are undefined at power-up
  always_ff @(posedge mclk) begin
    if (ram_wr_en) begin
      iram[ram_wr_addr] <= ram_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_rdata     = st_reg.mem_rd;
  assign work_rdata    = st_reg.work_rd;
  assign stack_rdata   = st_reg.stk_rd;
  assign operand_out   = st_reg.opr;
  assign extension_out = st_reg.ext;
  assign status_out    = status_word;
  assign stack_top_out = st_reg.tp;
  assign data_ptr_out  = {st_reg.dhi, st_reg.dlo};

endmodule : crf_core_regs

//--- src/crf_pkg.sv
package crf_pkg;

  // ----------------------------------------------------------------
  // Widths and address space
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned WIDE_W      = 16;
  localparam int unsigned IRAM_DEPTH  = 256;
  localparam logic [7:0]  SPR_BASE    = 8'h80;
  localparam logic [7:0]  BANK_SPAN   = 8'h08;
  localparam logic [7:0]  BIT_SPR_MIN = 8'h80;

  // ----------------------------------------------------------------
  // Special register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADDR_DPTR_LOW  = 8'h82;
  localparam logic [7:0] ADDR_DPTR_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PTR_SEL   = 8'h85;
  localparam logic [7:0] ADDR_PTR_STEP  = 8'h86;
  localparam logic [7:0] ADDR_PWR_SER   = 8'h87;
  localparam logic [7:0] ADDR_TMR01_CTL = 8'h88;
  localparam logic [7:0] ADDR_STATUS    = 8'hD0;
  localparam logic [7:0] ADDR_OPERAND   = 8'hE0;
  localparam logic [7:0] ADDR_EXTEND    = 8'hF0;

  // ----------------------------------------------------------------
  // Reset values and unoccupied read value
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_CARRY = 7;
  localparam int unsigned ST_HALF  = 6;
  localparam int unsigned ST_USER  = 5;
  localparam int unsigned ST_BSH   = 4;
  localparam int unsigned ST_BSL   = 3;
  localparam int unsigned ST_SERR  = 2;
  localparam int unsigned ST_PAR   = 0;

  // ----------------------------------------------------------------
  // Flag update operations from the execution unit
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CRF_OP_NONE,
    CRF_OP_ADD,
    CRF_OP_ADDC,
    CRF_OP_SUBB,
    CRF_OP_MUL,
    CRF_OP_DIV,
    CRF_OP_SHIFT,
    CRF_OP_VCLR,
    CRF_OP_OTHER_ARITH
  } crf_op_t;

  // Operation request: register operands are current values; the other operand or result byte comes with the request
  typedef struct packed {
    crf_op_t    op;
    logic [7:0] operand;
    logic       shift_carry;
  } crf_alu_req_t;

  // Memory or special register access request
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       direct;
    logic       bit_mode;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
    logic       wbit;
  } crf_mem_req_t;

  // Working register access
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] index;
    logic [7:0] wdata;
  } crf_work_req_t;

  // Stack operation
  typedef struct packed {
    logic       push;
    logic       pop;
    logic [7:0] wdata;
  } crf_stack_req_t;

endpackage : crf_pkg

//--- verif/crf_core_regs_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the core register set
// ----------------------------------------------------------------
module crf_core_regs_sva
  import crf_pkg::*;
(
  input wire logic           mclk,
  input wire logic           reset,
  input wire crf_alu_req_t   alu_req,
  input wire crf_mem_req_t   mem_req,
  input wire crf_stack_req_t stack_req,
  input wire logic [7:0]     operand_out,
  input wire logic [7:0]     extension_out,
  input wire logic [7:0]     status_out,
  input wire logic [7:0]     stack_top_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Direct byte write, and a cycle with no competing update
  wire wr_d  = mem_req.valid && mem_req.write && mem_req.direct && !mem_req.bit_mode;
  wire quiet = !stack_req.push && !stack_req.pop && alu_req.op == CRF_OP_NONE;

  a_parity_odd: assert property (status_out[ST_PAR] == ^operand_out)
    else $error("parity flag disagrees with operand register");
  a_add_result: assert property (alu_req.op == CRF_OP_ADD |=>
    {status_out[ST_CARRY], operand_out} == 9'($past(operand_out)) + 9'($past(alu_req.operand)))
    else $error("add result or carry wrong");
  a_add_half: assert property (alu_req.op == CRF_OP_ADD |=> status_out[ST_HALF] ==
    ((5'($past(operand_out[3:0])) + 5'($past(alu_req.operand[3:0]))) > 5'h0f))
    else $error("half carry wrong after add");
  a_user_kept: assert property (!(mem_req.valid && mem_req.write) |=>
    $stable(status_out[ST_USER]))
    else $error("user flag changed without a write");
  a_stack_step: assert property (stack_req.push || stack_req.pop |=>
    stack_top_out == 8'($past(stack_top_out) + ($past(stack_req.push) ? 8'h01 : 8'hff)))
    else $error("stack pointer step wrong");
  a_top_direct: assert property (wr_d && quiet && mem_req.addr == ADDR_STACK_TOP |=>
    stack_top_out == $past(mem_req.wdata))
    else $error("direct write missed stack pointer");
  a_top_indirect: assert property (mem_req.valid && mem_req.write && !mem_req.direct &&
    mem_req.addr == ADDR_STACK_TOP && quiet |=> $stable(stack_top_out))
    else $error("indirect write reached stack pointer");
  a_bank_follow: assert property (wr_d && quiet && mem_req.addr == ADDR_STATUS |=>
    status_out[ST_BSH:ST_BSL] == $past(mem_req.wdata[4:3]))
    else $error("bank bits did not follow status write");
  a_mul_wide: assert property (alu_req.op == CRF_OP_MUL |=>
    {extension_out, operand_out} == 16'($past(operand_out)) * 16'($past(extension_out))
    && status_out[ST_SERR] == ($past(extension_out) * $past(operand_out) > 255))
    else $error("multiply result or error flag wrong");
  a_div_zero: assert property (alu_req.op == CRF_OP_DIV && extension_out == 8'h00 |=>
    status_out[ST_SERR] && operand_out == 8'h00 && extension_out == 8'h00)
    else $error("divide by zero not flagged");
  a_clear_error: assert property (alu_req.op == CRF_OP_VCLR |=> !status_out[ST_SERR])
    else $error("clear instruction left error flag set");

  c_push: cover property (stack_req.push);
  c_div_zero: cover property (alu_req.op == CRF_OP_DIV && extension_out == 8'h00);
  c_bank3: cover property (status_out[ST_BSH:ST_BSL] == 2'b11);
endmodule : crf_core_regs_sva

bind crf_core_regs crf_core_regs_sva u_sva (.mclk(mclk), .reset(reset), .alu_req(alu_req),
  .mem_req(mem_req), .stack_req(stack_req), .operand_out(operand_out),
  .extension_out(extension_out), .status_out(status_out), .stack_top_out(stack_top_out));

//--- verif/crf_exec_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Execution unit model: one request per call, held for one edge
// ----------------------------------------------------------------
module crf_exec_model
  import crf_pkg::*;
(
  input  wire logic     mclk,
  output crf_alu_req_t   alu_req,
  output crf_mem_req_t   mem_req,
  output crf_work_req_t  work_req,
  output crf_stack_req_t stack_req
);
  // Idle at time zero
  initial begin
    alu_req = '0;
    mem_req = '0;
    work_req = '0;
    stack_req = '0;
  end

  // Callers write only occupied special addresses
  task automatic mem_op(input logic w, d, bm, input logic [7:0] a, input logic [2:0] s,
                        input logic [7:0] wd, input logic wb);
    @(posedge mclk); #1;
    mem_req = '{1'b1, w, d, bm, a, s, wd, wb};
    @(posedge mclk); #1;
    mem_req.valid = 1'b0;
    mem_req.wdata = ~wd; // Stale data never looks valid
  endtask : mem_op

  task automatic work_op(input logic w, input logic [2:0] i, input logic [7:0] wd);
    @(posedge mclk); #1;
    work_req = '{1'b1, w, i, wd};
    @(posedge mclk); #1;
    work_req.valid = 1'b0;
    work_req.wdata = ~wd;
  endtask : work_op

  task automatic alu_op(input crf_op_t op, input logic [7:0] v, input logic sc);
    @(posedge mclk); #1;
    alu_req = '{op, v, sc};
    @(posedge mclk); #1;
    alu_req.op = CRF_OP_NONE;
  endtask : alu_op

  task automatic stack_op(input logic pu, po, input logic [7:0] wd);
    @(posedge mclk); #1;
    stack_req = '{pu, po, wd};
    @(posedge mclk); #1;
    stack_req = '{1'b0, 1'b0, ~wd};
  endtask : stack_op
endmodule : crf_exec_model

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    crf_op_t op; logic [7:0] a, x, v, st, ea, ex; logic [2:0] ef, m; logic sc;
  } crf_case_t;
  logic           mclk, reset;
  crf_alu_req_t   alu_req;
  crf_mem_req_t   mem_req;
  crf_work_req_t  work_req;
  crf_stack_req_t stack_req;
  logic [7:0]     mem_rdata, work_rdata, stack_rdata, rd;
  logic [7:0]     operand_out, extension_out, status_out, stack_top_out;
  logic [15:0]    data_ptr_out;
  int             n_errors, num_checks;
  logic [7:0]     reg_addr [7] = '{8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87, 8'h88};
  // Arithmetic cases; flags are {carry, half, error} under a mask
  crf_case_t      tc [12] = '{
    '{CRF_OP_ADD,   8'h78, 8'h11, 8'h88, 8'h20, 8'h00, 8'h11, 3'b110, 3'b111, 1'b0},
    '{CRF_OP_ADD,   8'h40, 8'h11, 8'h40, 8'h20, 8'h80, 8'h11, 3'b001, 3'b111, 1'b0},
    '{CRF_OP_ADDC,  8'h01, 8'h11, 8'h01, 8'ha0, 8'h03, 8'h11, 3'b000, 3'b111, 1'b0},
    '{CRF_OP_SUBB,  8'h10, 8'h11, 8'h01, 8'h20, 8'h0f, 8'h11, 3'b010, 3'b111, 1'b0},
    '{CRF_OP_SUBB,  8'h00, 8'h11, 8'h01, 8'h20, 8'hff, 8'h11, 3'b110, 3'b111, 1'b0},
    '{CRF_OP_MUL,   8'h10, 8'h20, 8'h00, 8'h20, 8'h00, 8'h02, 3'b001, 3'b001, 1'b0},
    '{CRF_OP_MUL,   8'h03, 8'h04, 8'h00, 8'h24, 8'h0c, 8'h00, 3'b000, 3'b001, 1'b0},
    '{CRF_OP_DIV,   8'h64, 8'h07, 8'h00, 8'h24, 8'h0e, 8'h02, 3'b000, 3'b001, 1'b0},
    '{CRF_OP_DIV,   8'h05, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 3'b001, 3'b001, 1'b0},
    '{CRF_OP_VCLR,  8'h05, 8'h11, 8'h00, 8'h24, 8'h05, 8'h11, 3'b000, 3'b001, 1'b0},
    '{CRF_OP_SHIFT, 8'h00, 8'h11, 8'h81, 8'h20, 8'h81, 8'h11, 3'b100, 3'b100, 1'b1},
    '{CRF_OP_OTHER_ARITH, 8'h00, 8'h11, 8'h3c, 8'he0, 8'h3c, 8'h11, 3'b000, 3'b110, 1'b0}};

  // ----------------------------------------------------------------
  // Design, execution unit model, clock
  // ----------------------------------------------------------------
  crf_core_regs dut (.mclk(mclk), .reset(reset), .alu_req(alu_req), .mem_req(mem_req),
    .work_req(work_req), .stack_req(stack_req), .mem_rdata(mem_rdata),
    .work_rdata(work_rdata), .stack_rdata(stack_rdata), .operand_out(operand_out),
    .extension_out(extension_out), .status_out(status_out),
    .stack_top_out(stack_top_out), .data_ptr_out(data_ptr_out));
  crf_exec_model u_exec (.mclk(mclk), .alu_req(alu_req), .mem_req(mem_req),
    .work_req(work_req), .stack_req(stack_req));
  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wrm(input logic d, input logic [7:0] a, input logic [7:0] v);
    u_exec.mem_op(1'b1, d, 1'b0, a, 3'h0, v, 1'b0);
  endtask : wrm

  // Read data is registered, so it is settled when the call returns
  task automatic rdm(input logic d, input logic [7:0] a, output logic [7:0] v);
    u_exec.mem_op(1'b0, d, 1'b0, a, 3'h0, 8'h00, 1'b0);
    v = mem_rdata;
  endtask : rdm

  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Watchdog well beyond the under two hundred cycles the run needs
  initial begin
    #100us;
    n_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    check(stack_top_out, RST_STACK_TOP);
    check(status_out, 8'h00);
    check(data_ptr_out, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      rdm(1'b1, reg_addr[i], rd);
      check(rd, (i == 0) ? RST_STACK_TOP : RST_ZERO);
    end
    // Push lands just above bank 0, pop returns it
    u_exec.stack_op(1'b1, 1'b0, 8'h5a);
    check(stack_top_out, 8'h08);
    rdm(1'b0, 8'h08, rd);
    check(rd, 8'h5a);
    u_exec.stack_op(1'b0, 1'b1, 8'h00);
    check({stack_top_out, stack_rdata}, 16'h075a);
    // Every bank, written through the working port, seen in RAM
    for (int k = 0; k < 4; k++) begin
      wrm(1'b1, ADDR_STATUS, 8'(k << 3));
      u_exec.work_op(1'b1, 3'h5, 8'(8'ha0 + k));
      u_exec.work_op(1'b0, 3'h5, 8'h00);
      check(work_rdata, 8'(8'ha0 + k));
      rdm(1'b0, 8'(k * 8 + 5), rd);
      check(rd, 8'(8'ha0 + k));
    end
    // Upper half: indirect hits RAM, direct hits the registers
    wrm(1'b0, ADDR_STACK_TOP, 8'h33);
    check(stack_top_out, RST_STACK_TOP);
    rdm(1'b0, ADDR_STACK_TOP, rd);
    check(rd, 8'h33);
    wrm(1'b1, ADDR_STACK_TOP, 8'h20);
    check(stack_top_out, 8'h20);
    rdm(1'b1, 8'h84, rd);
    check(rd, UNMAPPED_READ);
    // Both pointer halves reach the wide output
    wrm(1'b1, ADDR_DPTR_LOW, 8'h34);
    wrm(1'b1, ADDR_DPTR_HIGH, 8'h12);
    check(data_ptr_out, 16'h1234);
    u_exec.mem_op(1'b1, 1'b1, 1'b1, ADDR_TMR01_CTL, 3'h3, 8'h00, 1'b1);
    rdm(1'b1, ADDR_TMR01_CTL, rd);
    check(rd, 8'h08);
    wrm(1'b1, ADDR_STATUS, 8'h00);
    u_exec.mem_op(1'b1, 1'b1, 1'b1, ADDR_STATUS, 3'h5, 8'h00, 1'b1);
    check(status_out, 8'h20);
    // Arithmetic table: the user flag must survive every operation
    for (int i = 0; i < 12; i++) begin
      wrm(1'b1, ADDR_OPERAND, tc[i].a);
      wrm(1'b1, ADDR_EXTEND, tc[i].x);
      wrm(1'b1, ADDR_STATUS, tc[i].st);
      u_exec.alu_op(tc[i].op, tc[i].v, tc[i].sc);
      check({extension_out, operand_out}, {tc[i].ex, tc[i].ea});
      check({status_out[ST_CARRY], status_out[ST_HALF], status_out[ST_SERR]} & tc[i].m,
            tc[i].ef & tc[i].m);
      check({status_out[ST_USER], status_out[ST_PAR]}, {1'b1, ^tc[i].ea});
    end
    // Reset again in mid-run
    @(posedge mclk);
    #1 reset = 1'b1;
    @(posedge mclk);
    #1 reset = 1'b0;
    check({stack_top_out, status_out}, 16'h0700);
    check(data_ptr_out, 16'h0000);
    finish_test();
  end
endmodule : tb
